// ### rmwcs_pkg.sv
// Purpose: constants and carrier types for the locked-cycle and cpu-space bus sequencer
// Assumes: one state per rising mclk edge, strobe half-phases folded into whole states
// Notes: function codes and space types as driven on the external bus
package rmwcs_pkg;

  localparam logic [3:0] RMWCS_FC_CPU = 4'h7;
  localparam logic [3:0] RMWCS_TYPE_BREAKPOINT_REQUEST = 4'h0;
  localparam logic [3:0] RMWCS_TYPE_MBASE = 4'h1;
  localparam logic [3:0] RMWCS_TYPE_LOW_POWER_STOP = 4'h3;
  localparam logic [3:0] RMWCS_TYPE_IACK = 4'hf;
  localparam logic [31:0] RMWCS_MBASE_ADDR = 32'h0003ff00;
  localparam logic [31:0] RMWCS_MBASE_RESET = 32'h00000000;
  localparam logic [31:0] RMWCS_BLOCK_MASK = 32'hfffff000;
  localparam logic [1:0] RMWCS_SIZE_BYTE = 2'h1;
  localparam logic [1:0] RMWCS_SIZE_WORD = 2'h2;
  localparam logic [2:0] RMWCS_HW_BREAKPOINT_REQUEST_NUM = 3'h7;
  localparam logic [2:0] RMWCS_MAX_XFERS = 3'h4;

  // requested operation kinds
  typedef enum logic [2:0] {
    RMWCS_OP_RMW,
    RMWCS_OP_SWBKPT,
    RMWCS_OP_HWBKPT,
    RMWCS_OP_LOW_POWER_STOP,
    RMWCS_OP_MBASE_WR,
    RMWCS_OP_MBASE_RD
  } rmwcs_op_type;

  typedef struct packed {
    rmwcs_op_type op;
    logic [31:0] addr;
    logic [3:0] fc;
    logic [1:0] size;
    logic [2:0] n_reads;
    logic [2:0] n_writes;
    logic [31:0] wdata;
    logic [2:0] breakpoint_request_num;
    logic [2:0] mask_level;
  } rmwcs_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] fc;
    logic [1:0] size;
    logic rd_wr;
    logic address_strobe_n;
    logic data_strobe_n;
    logic locked_cycle_indicator_n;
    logic [15:0] dout;
    logic dout_oe_n;
  } rmwcs_bus_type;

endpackage

// ### rmwcs_top.sv
// Purpose: sequences locked read-modify-write and cpu-space bus cycles
// Assumes: size_acknowledge and bus_error_in already synchronous to mclk, active low
// Notes: module base register is answered internally, no external cycle is run
`timescale 1ns/1ps

// Notes on behaviour
// - lock indicator spans reads through writes
// - no bus grant during locked sequence
// - read s0 drives lock, address, code, size
// - strobes asserted in read s1
// - latch on acknowledge, else wait states
// - repeat reads, hold address between portions
// - one idle state between read and write portions, skip writes
// - direction read until write s0
// - write s0 dir low, s1 strobe, s2 data, s3 ds
// - write ends two clocks after acknowledge
// - cpu space uses code seven, type bits
// - software breakpoint word read encoding
// - breakpoint bus error gives illegal instruction
// - hardware breakpoint encoding and outcomes
// - stop broadcast writes mask level, internal ack
// - relocatable base register at fixed cpu address
// - only four space types, others reserved
module rmwcs_top
  import rmwcs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // request port from the core
  input wire logic req_valid,
  input wire rmwcs_req_type req,
  output logic req_busy,
  output logic done,
  output logic [31:0] rdata,
  output logic fault_illegal,
  output logic fault_breakpoint_request,
  output logic breakpoint_request_acked,
  output logic stop_enter,
  output logic [31:0] module_block_base,
  // external bus
  output rmwcs_bus_type bus,
  input wire logic [15:0] din,
  input wire logic [1:0] size_acknowledge_n,
  input wire logic bus_error_in_n,
  input wire logic halt_in_n,
  // arbitration
  input wire logic bus_request_in_n,
  output logic bus_grant_out_n
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_WAIT, ST_S4, ST_S5, ST_GAP, ST_HALT, ST_DONE
  } rmwcs_state_type;

  rmwcs_state_type state_q, state_d;
  rmwcs_req_type req_q, req_d;
  rmwcs_bus_type bus_q, bus_d;
  logic writing_q, writing_d;
  logic [2:0] left_q, left_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] base_q, base_d;
  logic done_q, done_d;
  logic ill_q, ill_d;
  logic bkf_q, bkf_d;
  logic bka_q, bka_d;
  logic stop_q, stop_d;
  logic grant_n_q, grant_n_d;
  logic bus_error_in_seen_q, bus_error_in_seen_d;
  logic busy_q, busy_d;

  wire logic acked = (size_acknowledge_n != 2'h3);
  wire logic bus_error_in = !bus_error_in_n;
  wire logic internal_ack = (req_q.op == RMWCS_OP_LOW_POWER_STOP);

  function automatic logic [31:0] cpu_addr(input logic [3:0] stype, input logic [2:0] num, input logic tbit);
    logic [31:0] a;
    a = 32'h00000000;
    a[19:16] = stype;
    a[4:2] = num;
    a[1] = tbit;
    return a;
  endfunction

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    bus_d = bus_q;
    writing_d = writing_q;
    left_d = left_q;
    rdata_d = rdata_q;
    base_d = base_q;
    done_d = 1'b0;
    ill_d = 1'b0;
    bkf_d = 1'b0;
    bka_d = 1'b0;
    stop_d = 1'b0;
    bus_error_in_seen_d = bus_error_in_seen_q;
    grant_n_d = bus_request_in_n;
    if (state_q != ST_IDLE) begin
      grant_n_d = 1'b1;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (req_valid) begin
          req_d = req;
          bus_error_in_seen_d = 1'b0;
          writing_d = 1'b0;
          unique case (req.op)
            RMWCS_OP_MBASE_WR: begin
              base_d = req.wdata & RMWCS_BLOCK_MASK;
              state_d = ST_DONE;
            end
            RMWCS_OP_MBASE_RD: begin
              rdata_d = base_q;
              state_d = ST_DONE;
            end
            RMWCS_OP_SWBKPT: begin
              req_d.addr = cpu_addr(RMWCS_TYPE_BREAKPOINT_REQUEST, req.breakpoint_request_num, 1'b0);
              req_d.fc = RMWCS_FC_CPU;
              req_d.size = RMWCS_SIZE_WORD;
              req_d.n_reads = 3'h1;
              req_d.n_writes = 3'h0;
              state_d = ST_S0;
            end
            RMWCS_OP_HWBKPT: begin
              req_d.addr = cpu_addr(RMWCS_TYPE_BREAKPOINT_REQUEST, RMWCS_HW_BREAKPOINT_REQUEST_NUM, 1'b1);
              req_d.fc = RMWCS_FC_CPU;
              req_d.size = RMWCS_SIZE_WORD;
              req_d.n_reads = 3'h1;
              req_d.n_writes = 3'h0;
              state_d = ST_S0;
            end
            RMWCS_OP_LOW_POWER_STOP: begin
              req_d.addr = cpu_addr(RMWCS_TYPE_LOW_POWER_STOP, 3'h0, 1'b0);
              req_d.fc = RMWCS_FC_CPU;
              req_d.size = RMWCS_SIZE_WORD;
              req_d.wdata = {29'h0, req.mask_level};
              req_d.n_reads = 3'h0;
              req_d.n_writes = 3'h1;
              writing_d = 1'b1;
              state_d = ST_S0;
            end
            default: begin
              state_d = ST_S0;
              writing_d = (req.n_reads == 3'h0);
            end
          endcase
          left_d = (req.op == RMWCS_OP_LOW_POWER_STOP || (req.op == RMWCS_OP_RMW && req.n_reads == 3'h0))
                   ? req.n_writes : ((req.op == RMWCS_OP_RMW) ? req.n_reads : 3'h1);
        end
      end
      ST_S0: begin
        bus_d.addr = req_q.addr;
        bus_d.fc = req_q.fc;
        bus_d.size = req_q.size;
        bus_d.rd_wr = !writing_q;
        bus_d.locked_cycle_indicator_n = (req_q.op != RMWCS_OP_RMW);
        state_d = ST_S1;
      end
      ST_S1: begin
        bus_d.address_strobe_n = 1'b0;
        bus_d.data_strobe_n = writing_q;
        state_d = ST_S2;
      end
      ST_S2: begin
        if (writing_q) begin
          bus_d.dout = req_q.wdata[15:0];
          bus_d.dout_oe_n = 1'b0;
        end
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (writing_q) begin
          bus_d.data_strobe_n = 1'b0;
        end
        if (acked || bus_error_in || internal_ack) begin
          bus_error_in_seen_d = bus_error_in_seen_q | bus_error_in;
          state_d = ST_S4;
        end
      end
      ST_S4: begin
        if (!writing_q) begin
          rdata_d = {rdata_q[15:0], din};
        end
        state_d = ST_S5;
      end
      ST_S5: begin
        bus_d.address_strobe_n = 1'b1;
        bus_d.data_strobe_n = 1'b1;
        if (left_q > 3'h1) begin
          left_d = left_q - 3'h1;
          state_d = ST_S0;
        end else if (!writing_q && req_q.op == RMWCS_OP_RMW && req_q.n_writes != 3'h0) begin
          writing_d = 1'b1;
          left_d = req_q.n_writes;
          state_d = ST_GAP;
        end else if (internal_ack && !halt_in_n) begin
          state_d = ST_HALT;
        end else begin
          state_d = ST_DONE;
        end
      end
      ST_GAP: begin
        state_d = ST_S0;
      end
      ST_HALT: begin
        if (halt_in_n) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        bus_d.locked_cycle_indicator_n = 1'b1;
        bus_d.dout_oe_n = 1'b1;
        bus_d.rd_wr = 1'b1;
        done_d = 1'b1;
        if (req_q.op == RMWCS_OP_SWBKPT) begin
          ill_d = bus_error_in_seen_q;
        end
        if (req_q.op == RMWCS_OP_HWBKPT) begin
          bkf_d = bus_error_in_seen_q;
          bka_d = 1'b1;
        end
        if (req_q.op == RMWCS_OP_SWBKPT) begin
          bka_d = 1'b1;
        end
        stop_d = (req_q.op == RMWCS_OP_LOW_POWER_STOP);
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      bus_q <= '{addr: 32'h0, fc: 4'h0, size: 2'h0, rd_wr: 1'b1, address_strobe_n: 1'b1,
                 data_strobe_n: 1'b1, locked_cycle_indicator_n: 1'b1, dout: 16'h0, dout_oe_n: 1'b1};
      writing_q <= 1'b0;
      left_q <= 3'h0;
      rdata_q <= 32'h0;
      base_q <= RMWCS_MBASE_RESET;
      done_q <= 1'b0;
      ill_q <= 1'b0;
      bkf_q <= 1'b0;
      bka_q <= 1'b0;
      stop_q <= 1'b0;
      grant_n_q <= 1'b1;
      bus_error_in_seen_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      req_q <= req_d;
      bus_q <= bus_d;
      writing_q <= writing_d;
      left_q <= left_d;
      rdata_q <= rdata_d;
      base_q <= base_d;
      done_q <= done_d;
      ill_q <= ill_d;
      bkf_q <= bkf_d;
      bka_q <= bka_d;
      stop_q <= stop_d;
      grant_n_q <= grant_n_d;
      bus_error_in_seen_q <= bus_error_in_seen_d;
      busy_q <= busy_d;
    end
  end

  // busy kept in its own flop so the core sees no decode glitch
  assign req_busy = busy_q;
  assign done = done_q;
  assign rdata = rdata_q;
  assign fault_illegal = ill_q;
  assign fault_breakpoint_request = bkf_q;
  assign breakpoint_request_acked = bka_q;
  assign stop_enter = stop_q;
  assign module_block_base = base_q;
  assign bus = bus_q;
  assign bus_grant_out_n = grant_n_q;

  no_grant_locked_a: assert property (@(posedge mclk) disable iff (reset)
    !bus_q.locked_cycle_indicator_n |=> bus_grant_out_n)
    else $error("bus granted during locked sequence");
  strobe_after_s0_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state_q == ST_S1 && !writing_q |=> !bus_q.address_strobe_n && !bus_q.data_strobe_n)
    else $error("read strobes missing in s1");
  write_dir_low_a: assert property (@(posedge mclk) disable iff (reset)
    !bus_q.dout_oe_n |-> !bus_q.rd_wr)
    else $error("data driven while direction reads");
  lock_held_gap_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == ST_GAP |-> !bus_q.locked_cycle_indicator_n)
    else $error("lock dropped between portions");
  strobes_off_gap_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == ST_GAP |-> bus_q.address_strobe_n && bus_q.data_strobe_n)
    else $error("strobes asserted in idle gap");
  wait_no_ack_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state_q == ST_WAIT && !acked && !bus_error_in && !internal_ack |=> state_q == ST_WAIT)
    else $error("cycle left wait without acknowledge");
  cpu_space_fc_a: assert property (@(posedge mclk) disable iff (reset)
    !bus_q.address_strobe_n && req_q.op != RMWCS_OP_RMW |-> bus_q.fc == RMWCS_FC_CPU)
    else $error("cpu space cycle without code seven");
  hw_breakpoint_request_addr_a: assert property (@(posedge mclk) disable iff (reset)
    !bus_q.address_strobe_n && req_q.op == RMWCS_OP_HWBKPT |-> bus_q.addr[4:1] == 4'hf)
    else $error("hardware breakpoint address wrong");
  sw_breakpoint_request_ill_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state_q == ST_DONE && req_q.op == RMWCS_OP_SWBKPT |=> fault_illegal == $past(bus_error_in_seen_q))
    else $error("breakpoint bus error outcome wrong");
  base_aligned_a: assert property (@(posedge mclk) disable iff (reset)
    module_block_base[11:0] == 12'h000)
    else $error("module base not block aligned");
  rd_s0_setup_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state_q == ST_S0 && !writing_q && req_q.op == RMWCS_OP_RMW
    |=> !bus_q.locked_cycle_indicator_n && bus_q.rd_wr && bus_q.addr == $past(req_q.addr))
    else $error("read s0 setup wrong");
  gap_read_dir_a: assert property (@(posedge mclk) disable iff (reset)
    state_q == ST_GAP |-> bus_q.rd_wr && bus_q.dout_oe_n)
    else $error("direction or data changed before write s0");
  s5_strobes_off_a: assert property (@(posedge mclk) disable iff (reset)
    clk_en && state_q == ST_S5 |=> bus_q.address_strobe_n && bus_q.data_strobe_n)
    else $error("strobes still asserted after s5");
  stop_mask_a: assert property (@(posedge mclk) disable iff (reset)
    !bus_q.dout_oe_n && req_q.op == RMWCS_OP_LOW_POWER_STOP |-> bus_q.dout[2:0] == req_q.mask_level)
    else $error("stop broadcast mask level wrong");

  rmw_write_c: cover property (@(posedge mclk) disable iff (reset) state_q == ST_GAP ##2 state_q == ST_S1);
  stop_c: cover property (@(posedge mclk) disable iff (reset) stop_enter);
  hw_fault_c: cover property (@(posedge mclk) disable iff (reset) fault_breakpoint_request);
  halt_wait_c: cover property (@(posedge mclk) disable iff (reset) state_q == ST_HALT);
  stall_c: cover property (@(posedge mclk) disable iff (reset) !clk_en && state_q == ST_WAIT);

endmodule

// ### rmwcs_slave_model.sv
// Purpose: behavioural memory slave on the asynchronous bus
// Assumes: acts on falling mclk, strobes seen as registered by the sequencer
// Notes: released lines show inverted data so a stale read cannot pass
`timescale 1ns/1ps
module rmwcs_slave_model
  import rmwcs_pkg::*;
(
  // clock
  input wire logic mclk,
  // bus from the sequencer
  input rmwcs_bus_type bus,
  // scenario controls
  input wire logic [3:0] waits,
  input wire logic bus_error_in_mode,
  input wire logic [15:0] rd_word,
  // answers
  output logic [15:0] din,
  output logic [1:0] size_acknowledge_n,
  output logic bus_error_in_n
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    din = 16'h0000;
    size_acknowledge_n = 2'h3;
    bus_error_in_n = 1'b1;
  end
  always @(negedge mclk) begin
    if (!bus.address_strobe_n) begin
      // hold both acks high until the wait count runs out
      if (cnt >= waits) begin
        if (bus_error_in_mode) begin
          bus_error_in_n <= 1'b0;
        end else begin
          size_acknowledge_n <= 2'h0;
        end
        if (bus.rd_wr) begin
          din <= rd_word;
        end
      end
      cnt <= cnt + 4'h1;
    end else begin
      // strobes gone: let go within one clock
      cnt <= 4'h0;
      size_acknowledge_n <= 2'h3;
      bus_error_in_n <= 1'b1;
      din <= ~din;
    end
  end
endmodule

// ### tb_rmwcs_top.sv
// Purpose: directed bench for the locked-cycle and cpu-space sequencer
// Assumes: inputs driven on falling mclk, one request at a time
// Notes: halt and clock enable are each dropped in one scenario
`timescale 1ns/1ps
module tb_rmwcs_top;
  import rmwcs_pkg::*;
  logic mclk, reset, req_valid, req_busy, done, fault_illegal, fault_breakpoint_request, breakpoint_request_acked, stop_enter;
  logic bus_error_in_n, bus_request_in_n, bus_grant_out_n, bus_error_in_mode;
  logic clk_en, halt_in_n, breakpoint_request_arm, breakpoint_request;
  logic [31:0] rdata, module_block_base, wd_seen, ad_seen;
  logic [15:0] din, rd_word;
  logic [3:0] fc_seen, waits;
  logic [1:0] size_acknowledge_n;
  rmwcs_req_type req;
  rmwcs_bus_type bus;
  int n_errors, num_checks;

  rmwcs_top rmwcs_top_inst (.mclk(mclk), .reset(reset), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_busy(req_busy), .done(done), .rdata(rdata), .fault_illegal(fault_illegal), .fault_breakpoint_request(fault_breakpoint_request),
    .breakpoint_request_acked(breakpoint_request_acked), .stop_enter(stop_enter), .module_block_base(module_block_base), .bus(bus),
    .din(din), .size_acknowledge_n(size_acknowledge_n), .bus_error_in_n(bus_error_in_n), .halt_in_n(halt_in_n),
    .bus_request_in_n(bus_request_in_n), .bus_grant_out_n(bus_grant_out_n));
  rmwcs_slave_model rmwcs_slave_model_inst (.mclk(mclk), .bus(bus), .waits(waits), .bus_error_in_mode(bus_error_in_mode),
    .rd_word(rd_word), .din(din), .size_acknowledge_n(size_acknowledge_n), .bus_error_in_n(bus_error_in_n));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // bus watcher: what the slave saw, and no grant while locked
  always @(negedge mclk) begin
    if (!bus.address_strobe_n) begin
      ad_seen <= bus.addr;
      fc_seen <= bus.fc;
    end
    if (!req_busy) begin
      wd_seen <= 32'hffffffff;
    end else if (!bus.dout_oe_n && !bus.address_strobe_n) begin
      wd_seen <= {16'h0000, bus.dout};
    end
    // far-side breakpoint line stays up until its acknowledge cycle ends
    if (reset || breakpoint_request_acked) begin
      breakpoint_request <= 1'b0;
    end else if (breakpoint_request_arm) begin
      breakpoint_request <= 1'b1;
    end
    if (!bus.locked_cycle_indicator_n && !bus_grant_out_n) begin
      chk("grant_in_lock", 32'h1, 32'h0);
    end
    if (!bus.dout_oe_n && bus.rd_wr) begin
      chk("drive_in_read", 32'h1, 32'h0);
    end
  end

  task automatic run(input rmwcs_op_type op, input logic [3:0] fc, input logic [2:0] nr, input logic [2:0] nw,
                     input logic [31:0] wd, input logic [2:0] num);
    int k;
    req = '{op: op, addr: 32'h00012344, fc: fc, size: RMWCS_SIZE_WORD, n_reads: nr, n_writes: nw,
            wdata: wd, breakpoint_request_num: num, mask_level: num};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge mclk);
      k++;
    end
    chk("done", 32'h1, {31'h0, done});
  endtask

  initial begin
    n_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    waits = 4'h0;
    bus_error_in_mode = 1'b0;
    rd_word = 16'hbeef;
    bus_request_in_n = 1'b0;
    clk_en = 1'b1;
    halt_in_n = 1'b1;
    breakpoint_request_arm = 1'b0;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    // locked pair, two reads then a write, far side asking for the bus
    run(RMWCS_OP_RMW, 4'h5, 3'h2, 3'h1, 32'h0000a55a, 3'h0);
    chk("rmw_rdata", 32'hbeefbeef, rdata);
    chk("rmw_wdata", 32'h0000a55a, wd_seen);
    repeat (3) @(negedge mclk);
    chk("grant_after", 32'h0, {31'h0, bus_grant_out_n});
    // slow slave, read only, no write states
    waits = 4'h3;
    rd_word = 16'h1234;
    // clock enable dropped while the read sits in wait states
    fork
      run(RMWCS_OP_RMW, 4'h5, 3'h1, 3'h0, 32'h0000ffff, 3'h0);
      begin
        repeat (4) @(negedge mclk);
        clk_en = 1'b0;
        repeat (3) @(negedge mclk);
        clk_en = 1'b1;
      end
    join
    chk("slow_rdata", 32'h1234, {16'h0, rdata[15:0]});
    chk("no_write", 32'hffffffff, wd_seen);
    waits = 4'h0;
    // software breakpoint refused by bus error
    bus_error_in_mode = 1'b1;
    run(RMWCS_OP_SWBKPT, 4'h7, 3'h1, 3'h0, 32'h0, 3'h5);
    chk("sw_illegal", 32'h1, {31'h0, fault_illegal});
    chk("sw_fc", 32'h7, {28'h0, fc_seen});
    chk("sw_addr", 32'h00000014, {12'h0, ad_seen[19:16], 11'h0, ad_seen[4:0]});
    run(RMWCS_OP_HWBKPT, 4'h7, 3'h1, 3'h0, 32'h0, 3'h0);
    chk("hw_fault", 32'h1, {31'h0, fault_breakpoint_request});
    chk("hw_addr", 32'h1e, {27'h0, ad_seen[4:0]});
    bus_error_in_mode = 1'b0;
    breakpoint_request_arm = 1'b1;
    run(RMWCS_OP_HWBKPT, 4'h7, 3'h1, 3'h0, 32'h0, 3'h0);
    chk("hw_ack", 32'h2, {30'h0, breakpoint_request_acked, fault_breakpoint_request});
    breakpoint_request_arm = 1'b0;
    @(negedge mclk);
    chk("breakpoint_request_line", 32'h0, {31'h0, breakpoint_request});
    // stop broadcast with a mask level
    run(RMWCS_OP_LOW_POWER_STOP, 4'h7, 3'h0, 3'h1, 32'h0, 3'h5);
    chk("stop_enter", 32'h1, {31'h0, stop_enter});
    chk("stop_mask", 32'h5, {29'h0, wd_seen[2:0]});
    chk("stop_type", 32'h3, {28'h0, ad_seen[19:16]});
    // far side holds halt low to put off stop entry
    halt_in_n = 1'b0;
    fork
      run(RMWCS_OP_LOW_POWER_STOP, 4'h7, 3'h0, 3'h1, 32'h0, 3'h2);
      begin
        repeat (10) @(negedge mclk);
        chk("stop_held", 32'h1, {31'h0, req_busy});
        halt_in_n = 1'b1;
      end
    join
    chk("stop_late", 32'h1, {31'h0, stop_enter});
    // base register keeps only 4k-aligned bits
    chk("base_reset", 32'h0, module_block_base);
    run(RMWCS_OP_MBASE_WR, 4'h7, 3'h0, 3'h0, 32'h12345678, 3'h0);
    chk("base_wr", 32'h12345000, module_block_base);
    run(RMWCS_OP_MBASE_RD, 4'h7, 3'h0, 3'h0, 32'h0, 3'h0);
    chk("base_rd", 32'h12345000, rdata);
    report_and_stop();
  end

  // whole run needs about a hundred cycles
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule
